//--- verilog/homing_defines.svh
// Purpose: Constants of the homing sequencer.
// Assumes: One 250 MHz clock, synchronous active-high reset.
// Notes: Method numbers are 8-bit two's complement values.
//
// How it works
// R01: Homing runs only while the operating mode input holds value 6.
// R02: Control start bit high starts homing; clearing it stops homing.
// R03: Status bits 13/12/10 show running, interrupted, confirmed or completed.
// R04: On error bit 13 set, bit 12 clear, bit 10 shows standstill.
// R05: Home offset gives the distance from zero position to reference point.
// R06: Method number picks reference event and starting direction.
// R07: Switch search uses switch speed, index search uses zero speed.
// R08: One acceleration value serves for starting and braking in homing.
// R09: Running past the limit tolerance band stops the motor and faults.
// R10: Block is detected when motor current exceeds the current threshold.
// R11: After block detection motor keeps pushing for programmed milliseconds.
// R12: Methods 1 to 14, 33 and 34 end on the index pulse.
// R13: Methods 17 to 30 end on switches only, same travel as 1 to 14.
// R14: Negative methods home on block; only the listed block methods accepted.
// R15: Homing on block is accepted only with closed loop active.
// R16: Method 1 uses negative limit, method 2 positive limit, then index.
// R17: Methods 3, 4 use home switch left edge, 5, 6 right edge.
// R18: Methods 7 to 10 watch positive limit, 11 to 14 negative limit.
// R19: Method 17 uses negative limit, 18 positive limit, no index.
// R20: Methods 33 and 34 reference to the next index pulse only.
// R21: Method 35 takes present position, operation enabled not needed.
// R22: Host must enable switch inputs before homing with switches.
// R23: On reference event actual position is loaded with home offset.
`ifndef HOMING_DEFINES_SVH
`define HOMING_DEFINES_SVH

`define MODE_HOMING 8'h06
`define METHOD_INDEX_NEG 8'h21
`define METHOD_INDEX_POS 8'h22
`define METHOD_HERE 8'h23
`define METHOD_SWITCH_ONLY_LO 8'h11
`define METHOD_SWITCH_ONLY_HI 8'h1E
`define METHOD_NO_INDEX_SHIFT 8'h10

`define STATUS_RUNNING 3'h0
`define STATUS_STOPPED 3'h1
`define STATUS_CONFIRMED 3'h2
`define STATUS_COMPLETED 3'h3
`define STATUS_ERROR 3'h4

`define CLK_PERIOD_NS 32'h0000_0004
`define NS_PER_MS 32'h000F_4240
`define MS_CYCLES (`NS_PER_MS / `CLK_PERIOD_NS)

`endif

//--- verilog/homing_pkg.sv
// Purpose: Types shared by the homing sequencer files.
// Assumes: Nothing beyond the constants header.
// Notes: Codes are written out so traces read the same in every tool.
package homing_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEARCH = 3'b001,
        ST_PRESS = 3'b010,
        ST_INDEX = 3'b011,
        ST_SETTLE = 3'b100,
        ST_DONE = 3'b101,
        ST_ERROR = 3'b110
    } hstate_t;

    typedef enum logic [1:0] {
        REF_LIMIT = 2'b00,
        REF_HOME = 2'b01,
        REF_INDEX = 2'b10,
        REF_HERE = 2'b11
    } ref_kind_t;

endpackage

//--- verilog/method_decoder.sv
// Purpose: Turns a signed homing method number into travel settings.
// Assumes: Method is two's complement; purely combinational.
// Notes: Methods 17 to 30 fold onto 1 to 14 with the index step removed.
`timescale 1ns/1ns
`include "homing_defines.svh"

module method_decoder (
    input wire logic [7:0] method_i,
    output logic valid_o,
    output logic block_o,
    output logic use_index_o,
    output homing_pkg::ref_kind_t ref_kind_o,
    output logic limit_positive_o,
    output logic watch_limit_o,
    output logic left_edge_o
);
    import homing_pkg::*;

    logic [7:0] mag;
    logic no_index;
    logic [7:0] base;
    logic [7:0] rel;
    logic plain_ok;
    logic block_ok;

    assign block_o = method_i[7];
    assign mag = method_i[7] ? 8'(-method_i) : method_i;
    // see R13
    assign no_index = (mag >= `METHOD_SWITCH_ONLY_LO) && (mag <= `METHOD_SWITCH_ONLY_HI);
    assign base = no_index ? 8'(mag - `METHOD_NO_INDEX_SHIFT) : mag;
    assign rel = 8'(base - 8'h07);

    assign plain_ok = ((base >= 8'h01) && (base <= 8'h0E))
                      || (mag == `METHOD_INDEX_NEG) || (mag == `METHOD_INDEX_POS)
                      || (mag == `METHOD_HERE);
    // Block methods: -1..-2, -7..-14, -17..-18, -23..-30 only.
    assign block_ok = (mag <= `METHOD_SWITCH_ONLY_HI) && (base >= 8'h01)
                      && (base <= 8'h0E) && ((base <= 8'h02) || (base >= 8'h07)); // see R14
    assign valid_o = block_o ? block_ok : plain_ok;

    // see R12
    assign use_index_o = !no_index && (mag != `METHOD_HERE);

    // see R06
    assign ref_kind_o = (mag == `METHOD_HERE) ? REF_HERE :
                        (mag >= `METHOD_INDEX_NEG) ? REF_INDEX :
                        (base <= 8'h02) ? REF_LIMIT : REF_HOME;

    // For limit methods this is the target limit, for 7..14 the reversing limit.
    assign limit_positive_o = (base == 8'h02) || ((base >= 8'h07) && (base <= 8'h0A))
                              || (mag == `METHOD_INDEX_POS); // see R16 see R18 see R19
    assign watch_limit_o = (base >= 8'h07) && (base <= 8'h0E); // see R18
    assign left_edge_o = (base <= 8'h04) || ((base >= 8'h07) && !rel[1]); // see R17

endmodule

//--- verilog/homing_mode_sequencer.sv
// Purpose: Homing operating mode: finds the reference event and loads the home offset as position.
// Assumes: All inputs synchronous to REF_CLK_I; speeds are magnitudes.
// Notes: Speed demand is signed, positive moves toward the positive limit.
`timescale 1ns/1ns
`include "homing_defines.svh"

module homing_mode_sequencer #(
    parameter int unsigned CYCLES_PER_MS = `MS_CYCLES
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] MODE_OF_OPERATION_I,
    input wire logic CONTROL_START_I,
    input wire logic OPERATION_ENABLED_I,
    input wire logic CLOSED_LOOP_I,
    input wire logic [7:0] HOMING_METHOD_I,
    input wire logic [31:0] HOME_OFFSET_I,
    input wire logic [31:0] SWITCH_SPEED_I,
    input wire logic [31:0] ZERO_SPEED_I,
    input wire logic [31:0] HOMING_ACCEL_I,
    input wire logic [31:0] LIMIT_TOLERANCE_I,
    input wire logic [15:0] BLOCK_CURRENT_I,
    input wire logic [15:0] BLOCK_TIME_MS_I,
    input wire logic [15:0] MOTOR_CURRENT_I,
    input wire logic [31:0] ACTUAL_POSITION_I,
    input wire logic MOTOR_STANDSTILL_I,
    input wire logic INDEX_PULSE_I,
    input wire logic HOME_SWITCH_I,
    input wire logic NEG_LIMIT_I,
    input wire logic POS_LIMIT_I,
    output logic signed [31:0] SPEED_DEMAND_O,
    output logic [31:0] ACCEL_O,
    output logic DRIVE_ENABLE_O,
    output logic POSITION_LOAD_O,
    output logic [31:0] POSITION_VALUE_O,
    output logic STATUS_BIT10_O,
    output logic STATUS_BIT12_O,
    output logic STATUS_BIT13_O,
    output logic FAULT_O
);
    import homing_pkg::*;

    // ----------------------------
    // Method decoding
    // ----------------------------

    logic meth_valid;
    logic meth_block;
    logic meth_index;
    ref_kind_t meth_kind;
    logic meth_limit_pos;
    logic meth_watch;
    logic meth_left;

    method_decoder decode (
        .method_i(HOMING_METHOD_I),
        .valid_o(meth_valid),
        .block_o(meth_block),
        .use_index_o(meth_index),
        .ref_kind_o(meth_kind),
        .limit_positive_o(meth_limit_pos),
        .watch_limit_o(meth_watch),
        .left_edge_o(meth_left)
    );

    // ----------------------------
    // State and history registers
    // ----------------------------

    hstate_t state;
    hstate_t next_state;
    logic dir;
    logic next_dir;
    logic start_d;
    logic home_d;
    logic index_d;
    logic limit_d;
    logic [31:0] limit_entry;
    logic [31:0] ms_div;
    logic [15:0] ms_count;
    logic [2:0] next_status;

    // ----------------------------
    // Start, abort and acceptance
    // ----------------------------

    logic mode_ok;
    logic start_req;
    logic start_rise;
    logic accepted;
    logic active;

    assign mode_ok = (MODE_OF_OPERATION_I == `MODE_HOMING); // see R01
    assign start_req = mode_ok && CONTROL_START_I; // see R02
    assign start_rise = start_req && !start_d;
    // Block homing needs closed loop; only the present-position method
    // may run without the power stage being enabled.
    assign accepted = meth_valid
                      && (!meth_block || CLOSED_LOOP_I) // see R15 see R14
                      && ((meth_kind == REF_HERE) || OPERATION_ENABLED_I); // see R21
    assign active = (state == ST_SEARCH) || (state == ST_PRESS)
                    || (state == ST_INDEX) || (state == ST_SETTLE);

    // ----------------------------
    // Reference events
    // ----------------------------

    logic home_want;
    logic home_edge;
    logic index_rise;
    logic over_current;
    logic limit_ahead;
    logic limit_any;
    logic block_reached;
    logic stop_hit;

    // Moving positive a left edge is a rising switch, moving negative a falling one.
    assign home_want = dir ^ !meth_left; // see R17
    assign home_edge = (HOME_SWITCH_I != home_d) && (HOME_SWITCH_I == home_want);
    assign index_rise = INDEX_PULSE_I && !index_d;
    assign over_current = MOTOR_CURRENT_I > BLOCK_CURRENT_I; // see R10
    assign limit_ahead = dir ? POS_LIMIT_I : NEG_LIMIT_I;
    assign limit_any = POS_LIMIT_I || NEG_LIMIT_I;
    assign block_reached = meth_block && over_current; // see R10
    // The block stands in for the limit switch in every block method.
    assign stop_hit = meth_block ? block_reached : limit_ahead; // see R14

    // ----------------------------
    // Limit tolerance band
    // ----------------------------

    logic [31:0] run_on;
    logic [31:0] run_on_mag;
    logic band_exceeded;

    // Block homing has no switches to run past, so the band does not apply.
    assign run_on = ACTUAL_POSITION_I - limit_entry;
    assign run_on_mag = run_on[31] ? 32'(-run_on) : run_on;
    assign band_exceeded = active && !meth_block && limit_any && limit_d
                           && (run_on_mag > LIMIT_TOLERANCE_I); // see R09

    // ----------------------------
    // Block pressing timer
    // ----------------------------

    logic ms_tick;
    logic press_over;

    assign ms_tick = (ms_div == 32'(CYCLES_PER_MS - 1));
    assign press_over = (ms_count >= BLOCK_TIME_MS_I); // see R11

    // ----------------------------
    // Next state
    // ----------------------------

    logic found;
    logic [31:0] next_speed_mag;
    logic moving;

    // Reference event of the switch search for the selected method.
    assign found = (meth_kind == REF_LIMIT) ? stop_hit : home_edge;

    always_comb begin
        next_state = state;
        next_dir = dir;
        unique case (state)
            ST_IDLE, ST_DONE, ST_ERROR: begin
                if (start_rise && accepted) begin
                    unique case (meth_kind)
                        REF_HERE: begin
                            next_state = ST_SETTLE; // see R21
                        end
                        REF_INDEX: begin
                            next_state = ST_INDEX; // see R20
                            next_dir = meth_limit_pos;
                        end
                        REF_LIMIT: begin
                            next_state = ST_SEARCH; // see R16 see R19
                            next_dir = meth_limit_pos;
                        end
                        REF_HOME: begin
                            next_state = ST_SEARCH;
                            // Head for the wanted edge from either side of the switch.
                            next_dir = HOME_SWITCH_I ^ meth_left; // see R18
                        end
                    endcase
                end else if (start_rise) begin
                    next_state = ST_ERROR;
                end
            end
            ST_SEARCH: begin
                if (meth_kind == REF_LIMIT && found && meth_block) begin
                    next_state = ST_PRESS; // see R11
                end else if (found) begin
                    next_state = meth_index ? ST_INDEX : ST_SETTLE; // see R12 see R13
                    if (meth_kind == REF_LIMIT) begin
                        next_dir = !dir;
                    end
                end else if (meth_kind == REF_HOME && meth_watch && stop_hit
                             && (dir == meth_limit_pos)) begin
                    next_dir = !dir; // see R18
                end
            end
            ST_PRESS: begin
                if (press_over) begin
                    next_state = meth_index ? ST_INDEX : ST_SETTLE;
                    next_dir = !dir;
                end
            end
            ST_INDEX: begin
                if (index_rise) begin
                    next_state = ST_SETTLE; // see R12
                end
            end
            ST_SETTLE: begin
                if (MOTOR_STANDSTILL_I) begin
                    next_state = ST_DONE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (active && band_exceeded) begin
            next_state = ST_ERROR; // see R09
        end else if (active && !start_req) begin
            next_state = ST_IDLE; // see R02
        end
    end

    // ----------------------------
    // Status and drive demand
    // ----------------------------

    // The error code carries standstill in its low bit, so the motor
    // state shows live while the error stands.
    always_comb begin
        unique case (next_state)
            ST_SEARCH, ST_PRESS, ST_INDEX: next_status = `STATUS_RUNNING; // see R03
            ST_SETTLE: next_status = `STATUS_CONFIRMED; // see R03
            ST_DONE: next_status = `STATUS_COMPLETED; // see R03
            ST_ERROR: next_status = `STATUS_ERROR | {2'b00, MOTOR_STANDSTILL_I}; // see R04
            default: next_status = `STATUS_STOPPED; // see R03
        endcase
    end

    assign moving = (next_state == ST_SEARCH) || (next_state == ST_PRESS)
                    || (next_state == ST_INDEX);
    assign next_speed_mag = !moving ? 32'h0000_0000 :
                            (next_state == ST_INDEX) ? ZERO_SPEED_I : SWITCH_SPEED_I; // see R07

    // ----------------------------
    // Registers
    // ----------------------------

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state <= ST_IDLE;
            dir <= 1'b0;
        end else begin
            state <= next_state;
            dir <= next_dir;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            start_d <= 1'b0;
            home_d <= 1'b0;
            index_d <= 1'b0;
            limit_d <= 1'b0;
        end else begin
            start_d <= start_req;
            home_d <= HOME_SWITCH_I;
            index_d <= INDEX_PULSE_I;
            limit_d <= limit_any;
        end
    end

    // Entry point of the band is the position when a limit first closes.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            limit_entry <= 32'h0000_0000;
        end else if (limit_any && !limit_d) begin
            limit_entry <= ACTUAL_POSITION_I; // see R09
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || state != ST_PRESS || ms_tick) begin
            ms_div <= 32'h0000_0000;
        end else begin
            ms_div <= ms_div + 32'h0000_0001;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || state != ST_PRESS) begin
            ms_count <= 16'h0000;
        end else if (ms_tick) begin
            ms_count <= ms_count + 16'h0001; // see R11
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            SPEED_DEMAND_O <= 32'sh0000_0000;
            ACCEL_O <= 32'h0000_0000;
            DRIVE_ENABLE_O <= 1'b0;
        end else begin
            SPEED_DEMAND_O <= next_dir ? $signed(next_speed_mag)
                                       : $signed(32'(-next_speed_mag)); // see R07
            ACCEL_O <= HOMING_ACCEL_I; // see R08
            DRIVE_ENABLE_O <= moving;
        end
    end

    // Position is rewritten in the cycle the reference event is taken,
    // so it is applied no later than the edge on which the completed code reaches the status bits.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            POSITION_LOAD_O <= 1'b0;
            POSITION_VALUE_O <= 32'h0000_0000;
        end else begin
            POSITION_LOAD_O <= (next_state == ST_SETTLE) && (state != ST_SETTLE); // see R23
            POSITION_VALUE_O <= HOME_OFFSET_I; // see R05
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            STATUS_BIT10_O <= 1'b1;
            STATUS_BIT12_O <= 1'b0;
            STATUS_BIT13_O <= 1'b0;
        end else begin
            STATUS_BIT10_O <= next_status[0];
            STATUS_BIT12_O <= next_status[1];
            STATUS_BIT13_O <= next_status[2]; // see R04
        end
    end

    // Fault is sticky; a band violation in the same cycle as a new start wins.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            FAULT_O <= 1'b0;
        end else if (active && band_exceeded) begin
            FAULT_O <= 1'b1; // see R09
        end else if (start_rise) begin
            FAULT_O <= 1'b0;
        end
    end

endmodule

//--- testbench/homing_props.sv
// Purpose: Concurrent checks on the ports of the homing sequencer.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: A start counts only when the sequencer rests (idle, done or error).
`timescale 1ns/1ns
module homing_props (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] MODE_OF_OPERATION_I,
    input wire logic CONTROL_START_I,
    input wire logic CLOSED_LOOP_I,
    input wire logic [7:0] HOMING_METHOD_I,
    input wire logic [31:0] HOME_OFFSET_I,
    input wire logic [31:0] ZERO_SPEED_I,
    input wire logic [31:0] HOMING_ACCEL_I,
    input wire logic INDEX_PULSE_I,
    input wire logic signed [31:0] SPEED_DEMAND_O,
    input wire logic [31:0] ACCEL_O,
    input wire logic DRIVE_ENABLE_O,
    input wire logic POSITION_LOAD_O,
    input wire logic [31:0] POSITION_VALUE_O,
    input wire logic STATUS_BIT10_O,
    input wire logic STATUS_BIT12_O,
    input wire logic STATUS_BIT13_O,
    input wire logic FAULT_O
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    wire logic [2:0] st = {STATUS_BIT13_O, STATUS_BIT12_O, STATUS_BIT10_O};
    wire logic rest = !DRIVE_ENABLE_O && (st != 3'b010);

    sequence start_taken;
        $rose(CONTROL_START_I) && MODE_OF_OPERATION_I == 8'h06 && rest;
    endsequence

    a_mode_gate: assert property (MODE_OF_OPERATION_I != 8'h06 |=> !DRIVE_ENABLE_O)
        else $error("drive enabled outside homing mode");
    a_abort_stop: assert property (DRIVE_ENABLE_O && !CONTROL_START_I
        |=> !DRIVE_ENABLE_O && SPEED_DEMAND_O == 0 && st == 3'b001)
        else $error("abort did not stop homing");
    a_running_code: assert property (DRIVE_ENABLE_O |-> st == 3'b000)
        else $error("running status wrong");
    a_error_code: assert property (STATUS_BIT13_O |-> !STATUS_BIT12_O && !DRIVE_ENABLE_O)
        else $error("error status wrong");
    a_accel_follow: assert property (DRIVE_ENABLE_O |-> ACCEL_O == $past(HOMING_ACCEL_I))
        else $error("acceleration not passed on");
    a_load_offset: assert property (POSITION_LOAD_O |->
        st == 3'b010 && POSITION_VALUE_O == $past(HOME_OFFSET_I) ##1 !POSITION_LOAD_O)
        else $error("position load wrong");
    a_index_load: assert property (DRIVE_ENABLE_O && $rose(INDEX_PULSE_I) &&
        (SPEED_DEMAND_O == ZERO_SPEED_I || SPEED_DEMAND_O == -ZERO_SPEED_I) |=> POSITION_LOAD_O)
        else $error("index pulse not taken");
    a_block_refused: assert property (start_taken ##0 HOMING_METHOD_I[7] && !CLOSED_LOOP_I
        |=> STATUS_BIT13_O && !DRIVE_ENABLE_O)
        else $error("block homing accepted in open loop");
    a_here_loads: assert property (start_taken ##0 HOMING_METHOD_I == 8'h23 |=> POSITION_LOAD_O)
        else $error("present position not taken");
    a_fault_stop: assert property ($rose(FAULT_O) |-> STATUS_BIT13_O && SPEED_DEMAND_O == 0)
        else $error("fault without stop");
endmodule

bind homing_mode_sequencer homing_props props_u (.*);

//--- testbench/motor_model.sv
// Purpose: Motor, encoder index and switches seen by the homing sequencer.
// Assumes: The axis moves one count a cycle in the demanded direction.
// Notes: Runaway keeps the motor turning to provoke the tolerance fault.
`timescale 1ns/1ns
module motor_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic signed [31:0] speed_i,
    input wire logic load_i,
    input wire logic [31:0] value_i,
    input wire logic block_i,
    input wire logic runaway_i,
    output logic [31:0] pos_o,
    output logic still_o,
    output logic index_o,
    output logic home_o,
    output logic neg_lim_o,
    output logic pos_lim_o,
    output logic [15:0] current_o
);
    // ------------------------------------------------------------
    // Axis
    // ------------------------------------------------------------
    logic signed [31:0] pos;
    logic up;
    wire logic at_neg = pos < -100;
    wire logic at_pos = pos > 100;
    wire logic stuck = block_i && ((at_neg && !up) || (at_pos && up));
    wire logic dir = runaway_i ? up : (speed_i > 0);
    assign pos_o = pos;
    assign index_o = pos[3:0] == 4'h0;
    assign home_o = pos > -40 && pos < -20;
    // A mechanical block takes the place of the limit switches.
    assign neg_lim_o = at_neg && !block_i;
    assign pos_lim_o = at_pos && !block_i;
    assign current_o = stuck ? 16'h0100 : 16'h0010;
    always_ff @(posedge clk_i) begin
        still_o <= rst_i || (speed_i == 0 && !runaway_i);
        if (rst_i) begin
            pos <= 0;
            up <= 1'b0;
        end else if (load_i) begin
            pos <= $signed(value_i);
        end else if (runaway_i || speed_i != 0) begin
            up <= dir;
            pos <= stuck ? pos : (dir ? pos + 1 : pos - 1);
        end
    end
endmodule

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the homing sequencer.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: Milliseconds are cut to 4 cycles so block pushes stay short.
`timescale 1ns/1ns
module tb_top;
    // ------------------------------------------------------------
    // Signals, design and motor
    // ------------------------------------------------------------
    logic REF_CLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic [7:0] MODE_OF_OPERATION_I = 8'h06;
    logic CONTROL_START_I = 1'b0;
    logic OPERATION_ENABLED_I = 1'b0;
    logic CLOSED_LOOP_I = 1'b0;
    logic [7:0] HOMING_METHOD_I = 8'h23;
    logic [31:0] HOME_OFFSET_I = 32'h0000_0005;
    logic [31:0] SWITCH_SPEED_I = 32'h0000_0200;
    logic [31:0] ZERO_SPEED_I = 32'h0000_0040;
    logic [31:0] HOMING_ACCEL_I = 32'h0000_0077;
    logic [31:0] LIMIT_TOLERANCE_I = 32'h0000_0010;
    logic [15:0] BLOCK_CURRENT_I = 16'h0080;
    logic [15:0] BLOCK_TIME_MS_I = 16'h0002;
    logic block = 1'b0;
    logic runaway = 1'b0;
    wire logic [15:0] MOTOR_CURRENT_I;
    wire logic [31:0] ACTUAL_POSITION_I, ACCEL_O, POSITION_VALUE_O;
    wire logic MOTOR_STANDSTILL_I, INDEX_PULSE_I, HOME_SWITCH_I, NEG_LIMIT_I, POS_LIMIT_I;
    wire logic signed [31:0] SPEED_DEMAND_O;
    wire logic DRIVE_ENABLE_O, POSITION_LOAD_O, FAULT_O;
    wire logic STATUS_BIT10_O, STATUS_BIT12_O, STATUS_BIT13_O;
    wire logic [2:0] st = {STATUS_BIT13_O, STATUS_BIT12_O, STATUS_BIT10_O};
    logic [7:0] meth [7] = '{8'h21, 8'h22, 8'h01, 8'h02, 8'h11, 8'h12, 8'h19};
    logic [7:0] bad [3] = '{8'hFF, 8'h0F, 8'hFD};
    int n_errors = 0;
    int total_checks = 0;

    homing_mode_sequencer #(.CYCLES_PER_MS(4)) dut_u (.*);
    motor_model motor_u (.clk_i(REF_CLK_I), .rst_i(RST_I), .speed_i(SPEED_DEMAND_O),
        .load_i(POSITION_LOAD_O), .value_i(POSITION_VALUE_O), .block_i(block),
        .runaway_i(runaway), .pos_o(ACTUAL_POSITION_I), .still_o(MOTOR_STANDSTILL_I),
        .index_o(INDEX_PULSE_I), .home_o(HOME_SWITCH_I), .neg_lim_o(NEG_LIMIT_I),
        .pos_lim_o(POS_LIMIT_I), .current_o(MOTOR_CURRENT_I));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK_I);
        #1;
    endtask
    task automatic launch(input logic [7:0] m);
        CONTROL_START_I = 1'b0;
        HOMING_METHOD_I = m;
        cyc(1);
        CONTROL_START_I = 1'b1;
        cyc(1);
    endtask
    task automatic wait_load(input int bound);
        int k;
        for (k = 0; k < bound && POSITION_LOAD_O !== 1'b1; k++) cyc(1);
        chk("position load", 32'h1, {31'h0, POSITION_LOAD_O});
        chk("position value", HOME_OFFSET_I, POSITION_VALUE_O);
        cyc(3);
        chk("status", 32'h3, {29'h0, st});
        chk("actual position", HOME_OFFSET_I, ACTUAL_POSITION_I);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        forever #2 REF_CLK_I = ~REF_CLK_I;
    end
    initial begin
        #40000;
        n_errors++;
        end_of_test();
    end
    initial begin
        int k;
        logic [31:0] sp;
        cyc(6);
        RST_I = 1'b0;
        cyc(1);
        chk("status", 32'h1, {29'h0, st});
        launch(8'h23);
        wait_load(4);
        $display("test present_position done");
        OPERATION_ENABLED_I = 1'b1;
        for (int i = 0; i < 7; i++) begin
            HOME_OFFSET_I = 32'(i + 2);
            HOMING_ACCEL_I = 32'h0000_0100 + 32'(i);
            launch(meth[i]);
            cyc(1);
            sp = (i < 2) ? ZERO_SPEED_I : SWITCH_SPEED_I;
            chk("speed", i[0] ? sp : -sp, SPEED_DEMAND_O);
            chk("status", 32'h0, {29'h0, st});
            chk("accel", HOMING_ACCEL_I, ACCEL_O);
            wait_load(400);
        end
        $display("test method_table done");
        MODE_OF_OPERATION_I = 8'h03;
        launch(8'h21);
        cyc(2);
        chk("drive", 32'h0, {31'h0, DRIVE_ENABLE_O});
        MODE_OF_OPERATION_I = 8'h06;
        launch(8'h22);
        cyc(1);
        chk("drive", 32'h1, {31'h0, DRIVE_ENABLE_O});
        CONTROL_START_I = 1'b0;
        cyc(2);
        chk("status", 32'h1, {29'h0, st});
        chk("speed", 32'h0, SPEED_DEMAND_O);
        $display("test mode_and_abort done");
        for (int i = 0; i < 3; i++) begin
            launch(bad[i]);
            cyc(2);
            chk("status", 32'h5, {29'h0, st});
        end
        $display("test refused_methods done");
        CLOSED_LOOP_I = 1'b1;
        block = 1'b1;
        launch(8'hFF);
        for (k = 0; k < 300 && MOTOR_CURRENT_I <= BLOCK_CURRENT_I; k++) cyc(1);
        cyc(4);
        chk("speed", -SWITCH_SPEED_I, SPEED_DEMAND_O);
        wait_load(60);
        block = 1'b0;
        $display("test block_homing done");
        LIMIT_TOLERANCE_I = 32'h0000_0005;
        launch(8'h01);
        cyc(1);
        runaway = 1'b1;
        for (k = 0; k < 300 && FAULT_O !== 1'b1; k++) cyc(1);
        chk("fault", 32'h1, {31'h0, FAULT_O});
        chk("status", 32'h4, {29'h0, st});
        runaway = 1'b0;
        cyc(3);
        chk("status", 32'h5, {29'h0, st});
        LIMIT_TOLERANCE_I = 32'h0000_0100;
        launch(8'h23);
        wait_load(4);
        chk("fault", 32'h0, {31'h0, FAULT_O});
        $display("test tolerance_fault done");
        end_of_test();
    end
endmodule
